// File: frrc_fault_retry_response_ctrl.v
/*
  fault action controller for the input over-voltage fault: ignore, continue for a delay,
  disable and retry, or disable until cleared; counts restarts and spaces them by 2^n time units.
  assumes the action byte is written by the host command decoder through the documented command,
  and that the time-unit tick and the other fault, clear and command levels are on sys_clk.
  the fault input alone comes from an analogue comparator and is synchronised here.
  the byte resets to latch-off with no retry and a single time unit.
*/
`include "frrc_map.vh"

module frrc_fault_retry_response_ctrl #(
  parameter RESTART_CYCLES = `FRRC_RESTART_CYCLES
) (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       actWrite,
  input  wire [7:0] actWdata,
  output reg  [7:0] actRdata,
  input  wire       faultIn,
  input  wire       unitTick,
  input  wire       statusBitClear,
  input  wire       clearFaultsCmd,
  input  wire       resetIn,
  input  wire       outputOnCmd,
  input  wire       biasLost,
  input  wire       otherFaultStop,
  output reg        outputEnable,
  output reg        faultLatched,
  output reg        restarting,
  output reg  [2:0] attemptsLeft
);

  // run, continue for the delay, wait between attempts, restart pulse, latched off
  localparam ST_RUN     = 3'h0;
  localparam ST_CONT    = 3'h1;
  localparam ST_WAIT    = 3'h2;
  localparam ST_RESTART = 3'h3;
  localparam ST_LATCH   = 3'h4;

  reg  [7:0]  actReg;
  reg  [2:0]  stateReg;
  reg  [2:0]  stateNext;
  reg  [7:0]  delayCntReg;
  reg  [7:0]  delayCntNext;
  reg  [2:0]  triesReg;
  reg  [2:0]  triesNext;
  reg  [15:0] pulseCntReg;
  reg  [15:0] pulseCntNext;
  reg  [2:0]  faultSyncReg;
  reg         faultReg;
  reg         onCmdDlyReg;

  wire [1:0] respCode  = actReg[`FRRC_ACT_RESP_MSB:`FRRC_ACT_RESP_LSB];
  wire [2:0] retryCode = actReg[`FRRC_ACT_RETRY_MSB:`FRRC_ACT_RETRY_LSB];
  wire [2:0] delayCode = actReg[`FRRC_ACT_DELAY_MSB:`FRRC_ACT_DELAY_LSB];
  // 2^n units; count runs 0..2^n-1 on unit ticks
  wire [7:0] delayLast = (8'h01 << delayCode) - 8'h01;
  // code seven never counts down, so the attempt counter is left alone
  wire       retryEndless = (retryCode == `FRRC_RETRY_FOREVER);
  // off-then-on: rising edge of the combined on command
  wire       onRise    = outputOnCmd & ~onCmdDlyReg;
  wire       clearEvt  = statusBitClear | clearFaultsCmd | resetIn | onRise;
  // only endless retry listens to the stop causes
  wire       stopRetry = ~outputOnCmd | biasLost | otherFaultStop;
  wire       delayAtLast = (delayCntReg == delayLast);
  wire       delayDone = unitTick & delayAtLast;
  // last cycle of the restart pulse
  wire       pulseLast = (pulseCntReg == RESTART_CYCLES[15:0] - 16'h0001);

  always @(posedge sys_clk) begin
    if (srst) begin
      actReg       <= `FRRC_ACT_RESET;
      faultSyncReg <= 3'h0;
      faultReg     <= 1'b0;
      // on level at reset, so a command already on gives no false edge
      onCmdDlyReg  <= 1'b1;
    end else begin
      if (actWrite) begin
        actReg <= actWdata;
      end
      // three stages: the comparator output is not on sys_clk
      faultSyncReg <= {faultSyncReg[1:0], faultIn};
      // change accepted only when second and third stages agree
      if (faultSyncReg[2] == faultSyncReg[1]) begin
        faultReg <= faultSyncReg[2];
      end
      onCmdDlyReg <= outputOnCmd;
    end
  end

  always @* begin
    stateNext    = stateReg;
    delayCntNext = delayCntReg;
    triesNext    = triesReg;
    pulseCntNext = pulseCntReg;
    case (stateReg)
      ST_RUN: begin
        // the response is taken from the byte as it stands when the fault arrives
        delayCntNext = 8'h00;
        if (faultReg) begin
          case (respCode)
            `FRRC_RESP_IGNORE:   stateNext = ST_RUN;
            `FRRC_RESP_CONTINUE: stateNext = ST_CONT;
            `FRRC_RESP_RETRY: begin
              stateNext = (retryCode == `FRRC_RETRY_NONE) ? ST_LATCH : ST_WAIT;
              triesNext = retryCode;
            end
            default:             stateNext = ST_LATCH;
          endcase
        end
      end
      ST_CONT: begin
        // fault gone before the delay ends: carry on as if nothing happened
        if (!faultReg) begin
          stateNext = ST_RUN;
        end else if (unitTick) begin
          delayCntNext = delayCntReg + 8'h01;
          if (delayDone) begin
            delayCntNext = 8'h00;
            stateNext    = (retryCode == `FRRC_RETRY_NONE) ? ST_LATCH : ST_WAIT;
            triesNext    = retryCode;
          end
        end
      end
      ST_WAIT: begin
        // a clear event wins over a stop cause or a due attempt
        if (clearEvt) begin
          stateNext = ST_RUN;
          triesNext = 3'h0;
        end else if (retryEndless && stopRetry) begin
          stateNext = ST_LATCH;
        end else if (unitTick) begin
          delayCntNext = delayCntReg + 8'h01;
          if (delayDone) begin
            delayCntNext = 8'h00;
            pulseCntNext = 16'h0000;
            stateNext    = ST_RESTART;
            if (!retryEndless) begin
              triesNext = triesReg - 3'h1;
            end
          end
        end
      end
      ST_RESTART: begin
        // interval keeps running from the attempt start; it holds at the last count
        // so that a pulse longer than the interval cannot wrap the counter
        if (unitTick && !delayAtLast) begin
          delayCntNext = delayCntReg + 8'h01;
        end
        pulseCntNext = pulseCntReg + 16'h0001;
        if (pulseLast) begin
          // a fault still present at the end of the pulse is a failed attempt
          if (!faultReg) begin
            stateNext = ST_RUN;
            triesNext = 3'h0;
          end else if (retryEndless) begin
            stateNext = stopRetry ? ST_LATCH : ST_WAIT;
          end else if (triesReg == 3'h0) begin
            stateNext = ST_LATCH;
          end else begin
            stateNext = ST_WAIT;
          end
        end
      end
      ST_LATCH: begin
        // the fault is not looked at here; only a clear event reopens the output
        delayCntNext = 8'h00;
        if (clearEvt) begin
          stateNext = ST_RUN;
          triesNext = 3'h0;
        end
      end
      default: stateNext = ST_RUN;
    endcase
  end

  // every output except actRdata is a flip-flop fed from the next state; actRdata is fed from the byte and the write
  always @(posedge sys_clk) begin
    if (srst) begin
      stateReg     <= ST_RUN;
      delayCntReg  <= 8'h00;
      triesReg     <= 3'h0;
      pulseCntReg  <= 16'h0000;
      outputEnable <= 1'b0;
      faultLatched <= 1'b0;
      restarting   <= 1'b0;
      attemptsLeft <= 3'h0;
      actRdata     <= `FRRC_ACT_RESET;
    end else begin
      stateReg     <= stateNext;
      delayCntReg  <= delayCntNext;
      triesReg     <= triesNext;
      pulseCntReg  <= pulseCntNext;
      // output follows next state so the shutdown is seen the cycle after the fault is accepted
      outputEnable <= (stateNext == ST_RUN) | (stateNext == ST_CONT) | (stateNext == ST_RESTART);
      faultLatched <= (stateNext == ST_LATCH);
      restarting   <= (stateNext == ST_RESTART);
      // endless retry shows seven and is never stepped
      attemptsLeft <= triesNext;
      // readback carries a write in the same cycle as the byte itself
      actRdata     <= actWrite ? actWdata : actReg;
    end
  end

endmodule

// File: frrc_map.vh
/*
  register layout, reset value and timing constants of the fault action controller.
  assumes inclusion by the single design file; holds definitions only.
*/
`ifndef FRRC_MAP_VH
`define FRRC_MAP_VH

// action byte fields
`define FRRC_ACT_RESP_MSB    7
`define FRRC_ACT_RESP_LSB    6
`define FRRC_ACT_RETRY_MSB   5
`define FRRC_ACT_RETRY_LSB   3
`define FRRC_ACT_DELAY_MSB   2
`define FRRC_ACT_DELAY_LSB   0
`define FRRC_ACT_RESET       8'hc0

// response codes
`define FRRC_RESP_IGNORE     2'h0
`define FRRC_RESP_CONTINUE   2'h1
`define FRRC_RESP_RETRY      2'h2
`define FRRC_RESP_LATCH      2'h3

// retry codes
`define FRRC_RETRY_NONE      3'h0
`define FRRC_RETRY_FOREVER   3'h7

// restart pulse length in clock cycles
`define FRRC_RESTART_CYCLES  16'h0004

`endif

// File: frrc_host_model.sv
/* host side model: control pin and on/off bit give the on command, clear-faults arrives as a pulse.
   assumes requests come from the bench on sys_clk edges. */
module frrc_host_model (
  input  wire  sys_clk,
  input  wire  pinOn,
  input  wire  opOn,
  input  wire  clearReq,
  output logic outputOnCmd,
  output logic clearFaultsCmd
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge sys_clk) begin
    outputOnCmd <= pinOn && opOn;
    clearFaultsCmd <= clearReq;
  end
endmodule

// File: frrc_checker_sva.sv
/* checker of the fault action controller outputs.
   assumes one sys_clk domain, bound to the design top. */
module frrc_checker #(
  parameter RESTART_CYCLES = 4
) (
  input wire       sys_clk,
  input wire       srst,
  input wire [7:0] actRdata,
  input wire       statusBitClear,
  input wire       clearFaultsCmd,
  input wire       resetIn,
  input wire       outputOnCmd,
  input wire       outputEnable,
  input wire       faultLatched,
  input wire       restarting,
  input wire [2:0] attemptsLeft
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [15:0] runLen;
  always @(posedge sys_clk) runLen <= restarting ? runLen + 16'h1 : 16'h0;
  sequence s_back_on;
    !faultLatched && outputEnable ##1 outputEnable;
  endsequence
  a_ignore_keeps_on: assert property (actRdata[7:6] == 2'h0 && outputEnable && !restarting |=> outputEnable)
    else $error("output dropped under ignore code");
  a_latch_holds: assert property (faultLatched && !statusBitClear && !clearFaultsCmd && !resetIn
    && !$rose(outputOnCmd) |=> faultLatched) else $error("latch released without a clear");
  a_status_clear: assert property (faultLatched && statusBitClear |=> !faultLatched)
    else $error("status clear ignored");
  a_cmd_clear: assert property (faultLatched && clearFaultsCmd |=> s_back_on)
    else $error("clear command did not restore output");
  a_pin_clear: assert property (faultLatched && resetIn |=> !faultLatched)
    else $error("reset pin ignored");
  a_off_on_clear: assert property (faultLatched && $rose(outputOnCmd) |=> !faultLatched)
    else $error("off then on ignored");
  a_latched_off: assert property (faultLatched |-> !outputEnable)
    else $error("output on while latched");
  a_restart_len: assert property ($fell(restarting) |-> runLen == RESTART_CYCLES && $past(outputEnable))
    else $error("restart attempt length wrong");
  a_attempt_count: assert property ($rose(restarting) && actRdata[5:3] != 3'h7
    |-> attemptsLeft == $past(attemptsLeft) - 3'h1) else $error("attempt count not stepped");
endmodule
bind frrc_fault_retry_response_ctrl frrc_checker #(.RESTART_CYCLES(RESTART_CYCLES)) frrc_checker_i (
  .sys_clk(sys_clk), .srst(srst), .actRdata(actRdata), .statusBitClear(statusBitClear),
  .clearFaultsCmd(clearFaultsCmd), .resetIn(resetIn), .outputOnCmd(outputOnCmd), .outputEnable(outputEnable),
  .faultLatched(faultLatched), .restarting(restarting), .attemptsLeft(attemptsLeft));

// File: frrc_fault_retry_response_ctrl_tb_top.sv
/* bench: writes action bytes, injects faults, checks shutdown, retries, spacing and clears.
   assumes the host model drives the on command and the clear-faults pulse. */
module frrc_fault_retry_response_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 0, srst = 1, actWrite = 0, faultIn = 0, unitTick = 0, statusBitClear = 0;
  logic       resetIn = 0, otherFaultStop = 0, pinOn = 1, clearReq = 0, biasLost = 0;
  logic       outputEnable, faultLatched, restarting, outputOnCmd, clearFaultsCmd;
  logic [7:0] actWdata = 8'h00, actRdata;
  logic [2:0] attemptsLeft, tickCnt = 3'h0;
  int         num_errors = 0, compares = 0, cycles = 0, n;
  frrc_host_model frrc_host_model_i (.sys_clk(sys_clk), .pinOn(pinOn), .opOn(1'b1), .clearReq(clearReq),
    .outputOnCmd(outputOnCmd), .clearFaultsCmd(clearFaultsCmd));
  frrc_fault_retry_response_ctrl frrc_fault_retry_response_ctrl_i (.sys_clk(sys_clk), .srst(srst),
    .actWrite(actWrite), .actWdata(actWdata), .actRdata(actRdata), .faultIn(faultIn), .unitTick(unitTick),
    .statusBitClear(statusBitClear), .clearFaultsCmd(clearFaultsCmd), .resetIn(resetIn),
    .outputOnCmd(outputOnCmd), .biasLost(biasLost), .otherFaultStop(otherFaultStop),
    .outputEnable(outputEnable), .faultLatched(faultLatched), .restarting(restarting),
    .attemptsLeft(attemptsLeft));
  initial forever #2.5 sys_clk = ~sys_clk;
  // one time unit every 8 cycles keeps the delays short
  always @(posedge sys_clk) begin
    tickCnt <= tickCnt + 3'h1;
    unitTick <= (tickCnt == 3'h7);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic cyc(int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [7:0] v);
    actWrite <= 1'b1;
    actWdata <= v;
    cyc(1);
    actWrite <= 1'b0;
    cyc(1);
    chk(actRdata, v);
  endtask
  task automatic clr(string s);
    faultIn <= 1'b0;
    cyc(6);
    clearReq <= 1'b1;
    cyc(1);
    clearReq <= 1'b0;
    cyc(3);
    chk({faultLatched, outputEnable}, 8'h1);
    $display("test %s done at %0t", s, $time);
  endtask
  task automatic close_out();
    $display("compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    cyc(12);
    srst <= 1'b0;
    cyc(2);
    chk({actRdata[7:0]}, 8'hc0);
    wr(8'h00);
    faultIn <= 1'b1;
    cyc(40);
    chk(outputEnable, 8'h1);
    clr("ignore");
    wr(8'hc0);
    for (int k = 0; k < 4; k++) begin
      faultIn <= 1'b1;
      cyc(8);
      chk({faultLatched, outputEnable}, 8'h2);
      faultIn <= 1'b0;
      cyc(6);
      case (k)
        0: statusBitClear <= 1'b1;
        1: clearReq <= 1'b1;
        2: resetIn <= 1'b1;
        default: pinOn <= 1'b0;
      endcase
      cyc(2);
      {statusBitClear, clearReq, resetIn, pinOn} <= 4'b0001;
      cyc(4);
      chk({faultLatched, outputEnable}, 8'h1);
    end
    for (int r = 0; r < 7; r++) begin
      wr({2'h2, r[2:0], r[2:0]});
      faultIn <= 1'b1;
      n = 0;
      for (int c = 0; c < 4000 && faultLatched !== 1'b1; c++) begin
        cyc(1);
        n += (restarting === 1'b1);
      end
      chk(8'(n), 8'(r * 4));
      clr("retry count");
    end
    wr(8'h8b);
    faultIn <= 1'b1;
    for (n = 0; n < 20 && outputEnable !== 1'b0; n++) cyc(1);
    chk(attemptsLeft, 8'h1);
    for (n = 0; n < 200 && restarting !== 1'b1; n++) cyc(1);
    chk(n >= 55 && n <= 66, 8'h1);
    cyc(10);
    chk(faultLatched, 8'h1);
    clr("retry spacing");
    wr(8'h42);
    faultIn <= 1'b1;
    cyc(12);
    chk(outputEnable, 8'h1);
    cyc(60);
    chk(faultLatched, 8'h1);
    clr("continue");
    for (int s = 0; s < 3; s++) begin
      wr(8'hb8);
      faultIn <= 1'b1;
      cyc(80);
      chk(faultLatched, 8'h0);
      {biasLost, otherFaultStop, pinOn} <= {s == 0, s == 1, s != 2};
      cyc(40);
      chk(faultLatched, 8'h1);
      {biasLost, otherFaultStop, pinOn} <= 3'b001;
      clr("continuous");
    end
    close_out();
  end
endmodule
